/* hw/cantrx_map.vh */
// Constants for the CAN transceiver control block: register offsets, fields, timing.
// Assumes a 250 MHz APB clock and 32-bit data with one aligned word per register.
`ifndef CANTRX_MAP_VH
`define CANTRX_MAP_VH

// Register byte offsets
`define CANTRX_COMMAND_REGISTER_ZERO_ADDR 12'h000
`define CANTRX_OPERATING_STATUS_REGISTER_ZERO_ADDR 12'h004
`define CANTRX_DIAG_ADDR 12'h008
`define CANTRX_IRQ_STAT_ADDR 12'h00C
`define CANTRX_IRQ_MASK_ADDR 12'h010

// command_register_zero fields
`define CANTRX_CMD_WAKE_CLEAR_BIT_BIT 0
`define CANTRX_CMD_RXONLY_BIT 1
// operating_status_register_zero fields
`define CANTRX_OPS_WAKE_BIT 0
`define CANTRX_OPS_RXONLY_BIT 1
`define CANTRX_OPS_SLEEP_BIT 2
`define CANTRX_OPS_STRAP_BIT 3
// communication_diagnosis_register fields
`define CANTRX_DIAG_CLAMP_BIT 0
`define CANTRX_DIAG_TXTO_BIT 1
`define CANTRX_DIAG_OT_BIT 2
// Interrupt status/mask fields: wake, clamp, tx timeout, overtemp
`define CANTRX_IRQ_W 4

// Timing figures as printed
`define CANTRX_CLK_MHZ 250
`define CANTRX_WAKE_FILT_NS 750
`define CANTRX_DOM_DET_US 4000

`define CANTRX_ZERO32 32'h0000_0000
`endif

/* hw/cantrx_dom_timer.v */
// Counts consecutive cycles of an active level and flags when a limit is reached.
// Assumes the level is already synchronous to the clock.
module cantrx_dom_timer #(
   parameter CNT_W = 21,
   parameter [CNT_W-1:0] LIMIT = 21'd1
) (
   input wire pclk,
   input wire presetn,
   input wire level,
   output reg expired
);
   reg [CNT_W-1:0] cnt_reg;

   // Restart on every release, saturate at the limit
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= {CNT_W{1'b0}};
         expired <= 1'b0;
      end else if (!level) begin
         cnt_reg <= {CNT_W{1'b0}};
         expired <= 1'b0;
      end else if (cnt_reg != LIMIT) begin
         cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         expired <= (cnt_reg == LIMIT - {{(CNT_W-1){1'b0}}, 1'b1});
      end
   end
endmodule // cantrx_dom_timer

/* hw/cantrx_sync.v */
// Two-flop synchroniser for one bit.
// Assumes the input may change at any time relative to pclk.
module cantrx_sync #(
   parameter [0:0] RESET_VAL = 1'b1
) (
   input wire pclk,
   input wire presetn,
   input wire d,
   output reg q
);
   reg meta_reg;

   // First stage feeds only the second
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // cantrx_sync

/* hw/cantrx_top.v */
// Digital control of a high speed CAN transceiver: mode gating, remote wake, diagnosis, APB registers.
// Assumes bus data is 1 = recessive, 0 = dominant; driver enable is active high; APB at 250 MHz.
// Limitation: overtemperature arrives as a digital level and is not filtered here.
// Limitation: the mode pin is registered, so gating lags a mode change by one edge.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`include "cantrx_map.vh"

module cantrx_top #(
   parameter DOM_CYCLES = `CANTRX_DOM_DET_US * `CANTRX_CLK_MHZ
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire tx_data_input,
   output reg rx_data_output,
   input wire bus_rx_state,
   output reg bus_tx_data,
   output reg bus_drv_en,
   input wire rx_only_mode,
   input wire sleep_state,
   input wire wake_enable_strap,
   input wire overtemp_in,
   output reg irq
);

   // Filter length rounded up so the filter never undercuts its lower bound
   localparam WAKE_CYC = (`CANTRX_WAKE_FILT_NS * `CANTRX_CLK_MHZ + 999) / 1000;
   // Counter widths are fixed; the defaults fit with room to spare
   localparam [7:0] WAKE_LIMIT = WAKE_CYC[7:0];
   localparam [21:0] DOM_LIMIT = DOM_CYCLES[21:0];
   localparam IRQ_W = `CANTRX_IRQ_W;
   // Wake states
   localparam [2:0] WK_ARM = 3'b001;
   localparam [2:0] WK_FILT = 3'b010;
   localparam [2:0] WK_WAIT = 3'b100;

   // Wake filter state
   reg [2:0] wk_state_reg;
   reg [2:0] wk_state_next;
   reg [7:0] wk_cnt_reg;
   reg [7:0] wk_cnt_next;
   reg wake_reg;
   reg wake_set;

   // Mode copy, diagnosis flags, interrupt registers
   reg rx_only_reg;
   reg clamp_reg;
   reg txto_reg;
   reg ot_reg;
   reg [IRQ_W-1:0] irq_stat_reg;
   reg [IRQ_W-1:0] irq_mask_reg;

   // Read path
   reg [31:0] rd_mux;
   reg addr_ok;

   // Internal nets
   wire bus_sync;
   wire tx_dom_sync;
   wire clamp_hit;
   wire txto_hit;
   wire wr_acc;
   wire wake_clr;
   wire [IRQ_W-1:0] irq_events;

   // Bus state into the clock domain before any timing
   // Reset recessive so leaving reset never looks like a dominant edge
   cantrx_sync #(.RESET_VAL(1'b1)) u_bus_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(bus_rx_state),
      .q(bus_sync)
   );

   // Transmit input taken as synchronous; inverted so high means dominant
   assign tx_dom_sync = ~tx_data_input;

   // Long-dominant detectors, running in every mode
   // One shared length; a parameter so short benches can reach it
   cantrx_dom_timer #(.CNT_W(22), .LIMIT(DOM_LIMIT)) u_clamp_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .level(~bus_sync),
      .expired(clamp_hit)
   );
   cantrx_dom_timer #(.CNT_W(22), .LIMIT(DOM_LIMIT)) u_txto_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .level(tx_dom_sync),
      .expired(txto_hit)
   );

   // Register write decode, shared by every writable register
   function reg_wr;
      input acc;
      input [11:0] addr;
      input [11:0] target;
      begin
         reg_wr = acc && (addr == target);
      end
   endfunction

   // Writes land only on the edge where the master sees pready high
   assign wr_acc = psel && penable && pwrite && pready;
   assign wake_clr = reg_wr(wr_acc, paddr, `CANTRX_COMMAND_REGISTER_ZERO_ADDR) && pwdata[`CANTRX_CMD_WAKE_CLEAR_BIT_BIT];

   // Data path; the mode latches on the edge, driver follows it
   // Receive path is never gated: listening stays on in both modes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_only_reg <= 1'b0;
         bus_drv_en <= 1'b0;
         bus_tx_data <= 1'b1;
         rx_data_output <= 1'b1;
      end else begin
         rx_only_reg <= rx_only_mode;
         bus_drv_en <= ~rx_only_mode;
         bus_tx_data <= rx_only_mode ? 1'b1 : tx_data_input;
         rx_data_output <= bus_rx_state;
      end
   end

   // Wake filter: armed by recessive, filters dominant, then waits for recessive
   always @* begin
      wk_state_next = wk_state_reg;
      wk_cnt_next = wk_cnt_reg;
      wake_set = 1'b0;
      case (wk_state_reg)
         WK_ARM: begin
            // Waiting for dominant after a recessive stretch
            wk_cnt_next = 8'h00;
            if (!bus_sync && sleep_state && wake_enable_strap) begin
               wk_state_next = WK_FILT;
            end
         end
         WK_FILT: begin
            // Any recessive sample or loss of sleep or strap restarts the filter
            if (bus_sync || !sleep_state || !wake_enable_strap) begin
               wk_state_next = WK_ARM;
            end else if (wk_cnt_reg == WAKE_LIMIT) begin
               wake_set = 1'b1;
               wk_state_next = WK_WAIT;
            end else begin
               wk_cnt_next = wk_cnt_reg + 8'h01;
            end
         end
         WK_WAIT: begin
            // Clamped dominant stays here, no re-trigger
            if (bus_sync) begin
               wk_state_next = WK_ARM;
            end
         end
         default: begin
            wk_state_next = WK_ARM;
         end
      endcase
   end

   // Wake state register; starts waiting for recessive
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wk_state_reg <= WK_WAIT;
         wk_cnt_reg <= 8'h00;
      end else begin
         wk_state_reg <= wk_state_next;
         wk_cnt_reg <= wk_cnt_next;
      end
   end

   // Wake flag: set wins over clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_reg <= 1'b0;
      end else if (wake_set) begin
         wake_reg <= 1'b1;
      end else if (wake_clr) begin
         wake_reg <= 1'b0;
      end
   end

   // Diagnosis flags follow detectors only; no configuration touched
   // Live status: a flag drops as soon as its condition goes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clamp_reg <= 1'b0;
         txto_reg <= 1'b0;
         ot_reg <= 1'b0;
      end else begin
         clamp_reg <= clamp_hit;
         txto_reg <= txto_hit;
         ot_reg <= overtemp_in;
      end
   end

   // Rising edges of each flag raise sticky interrupt bits
   // Flag copies reset low, matching idle, so reset gives no false edge
   assign irq_events = {flag_rise(ot_reg, overtemp_in), flag_rise(txto_reg, txto_hit),
                        flag_rise(clamp_reg, clamp_hit), wake_set};

   // Rise of a level against its registered copy
   function flag_rise;
      input prev;
      input cur;
      begin
         flag_rise = cur & ~prev;
      end
   endfunction

   // Set wins over a same-cycle write-one clear, so no event is lost
   // irq sees new events at once; a mask or clear write shows one edge later
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= {IRQ_W{1'b0}};
         irq_mask_reg <= {IRQ_W{1'b0}};
         irq <= 1'b0;
      end else begin
         if (reg_wr(wr_acc, paddr, `CANTRX_IRQ_STAT_ADDR)) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_events;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_events;
         end
         if (reg_wr(wr_acc, paddr, `CANTRX_IRQ_MASK_ADDR)) begin
            irq_mask_reg <= pwdata[IRQ_W-1:0];
         end
         irq <= |((irq_stat_reg | irq_events) & irq_mask_reg);
      end
   end

   // Read mux
   // Unmapped offsets read zero and flag an error
   always @* begin
      rd_mux = `CANTRX_ZERO32;
      addr_ok = 1'b1;
      case (paddr)
         `CANTRX_COMMAND_REGISTER_ZERO_ADDR: begin
            rd_mux = `CANTRX_ZERO32;
         end
         `CANTRX_OPERATING_STATUS_REGISTER_ZERO_ADDR: begin
            rd_mux[`CANTRX_OPS_WAKE_BIT] = wake_reg;
            rd_mux[`CANTRX_OPS_RXONLY_BIT] = rx_only_reg;
            rd_mux[`CANTRX_OPS_SLEEP_BIT] = sleep_state;
            rd_mux[`CANTRX_OPS_STRAP_BIT] = wake_enable_strap;
         end
         `CANTRX_DIAG_ADDR: begin
            rd_mux[`CANTRX_DIAG_CLAMP_BIT] = clamp_reg;
            rd_mux[`CANTRX_DIAG_TXTO_BIT] = txto_reg;
            rd_mux[`CANTRX_DIAG_OT_BIT] = ot_reg;
         end
         `CANTRX_IRQ_STAT_ADDR: begin
            rd_mux[IRQ_W-1:0] = irq_stat_reg;
         end
         `CANTRX_IRQ_MASK_ADDR: begin
            rd_mux[IRQ_W-1:0] = irq_mask_reg;
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
   end

   // APB slave: one wait state, pready pulses in the access phase
   // prdata holds after the pulse; only the pready edge qualifies it
   // A write takes effect on the edge where pready is seen high
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `CANTRX_ZERO32;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= ~addr_ok;
         prdata <= pwrite ? `CANTRX_ZERO32 : rd_mux;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule // cantrx_top

/* verif/cantrx_props.sv */
// Checker for the transceiver control block: mode gating, data path, APB answer, irq mask.
// Assumes it is bound to the top module and sees only its ports.
`include "cantrx_map.vh"
module cantrx_props #(
   parameter DOM_CYCLES = 20
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire tx_data_input,
   input wire rx_data_output,
   input wire bus_rx_state,
   input wire bus_tx_data,
   input wire bus_drv_en,
   input wire rx_only_mode,
   input wire irq
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access cycle still waiting for its answer
   sequence apb_acc;
      psel && penable && !pready;
   endsequence
   // Mask write of all zeros completing
   sequence mask_clr;
      apb_acc ##1 pready && pwrite && paddr == `CANTRX_IRQ_MASK_ADDR && pwdata[3:0] == 4'h0;
   endsequence
   drv_off_a: assert property (rx_only_mode |=> !bus_drv_en) else $error("driver on in receive-only");
   tx_block_a: assert property (rx_only_mode |=> bus_tx_data) else $error("tx leaked to bus");
   drv_follow_a: assert property (!rx_only_mode |=> bus_drv_en && bus_tx_data == $past(tx_data_input))
      else $error("tx path wrong in normal mode");
   rx_fwd_a: assert property (1'b1 |=> rx_data_output == $past(bus_rx_state)) else $error("rx not forwarded");
   apb_answer_a: assert property (apb_acc |=> pready) else $error("no answer after access");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   bad_addr_a: assert property ((apb_acc ##0 paddr > 12'h010) |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   irq_masked_a: assert property (mask_clr |-> ##2 !irq) else $error("irq high with mask cleared");
endmodule // cantrx_props

bind cantrx_top cantrx_props #(.DOM_CYCLES(DOM_CYCLES)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .tx_data_input(tx_data_input), .rx_data_output(rx_data_output),
   .bus_rx_state(bus_rx_state), .bus_tx_data(bus_tx_data), .bus_drv_en(bus_drv_en),
   .rx_only_mode(rx_only_mode), .irq(irq));

/* verif/cantrx_ctrl_model.sv */
// Protocol controller model: shifts a 16-bit frame onto the transmit input, MSB first.
// Assumes the bench pulses go for one cycle; idle line is recessive (1).
module cantrx_ctrl_model (
   input wire pclk,
   input wire presetn,
   input wire go,
   input wire hold_dom,
   input wire [15:0] frame,
   output logic tx_data_input
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] sh_reg;
   logic [4:0] cnt_reg;
   // Shift register; recessive fill so a short frame never leaves dominant behind
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_reg <= 16'hFFFF;
         cnt_reg <= 5'h00;
      end else if (go) begin
         sh_reg <= frame;
         cnt_reg <= 5'h10;
      end else if (cnt_reg != 5'h00) begin
         sh_reg <= {sh_reg[14:0], 1'b1};
         cnt_reg <= cnt_reg - 5'h01;
      end
   end
   // Stuck-dominant request overrides the frame
   assign tx_data_input = hold_dom ? 1'b0 : ((cnt_reg != 5'h00) ? sh_reg[15] : 1'b1);
endmodule // cantrx_ctrl_model

/* verif/test_can_transceiver_mode_wake_diag.sv */
// Testbench: APB tasks, frame path in both modes, diagnosis, irq, wake filter.
// Assumes a short DOM_CYCLES of 20 and a wired-AND bus built here.
`include "cantrx_map.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_can_transceiver_mode_wake_diag;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, rx_only_mode, sleep_state, wake_enable_strap, overtemp_in;
   logic go, hold_dom, ext_n, p, q, err_q, pready, pslverr, tx_data_input, rx_data_output, bus_tx_data, bus_drv_en, irq;
   logic [11:0] paddr;
   logic [15:0] frame;
   logic [31:0] pwdata, prdata, rd_q;
   int failures, total_checks, cyc, m;
   // Wired-AND bus: our driver when enabled, plus a foreign dominant node
   wire bus_rx_state = (bus_drv_en ? bus_tx_data : 1'b1) & ext_n;
   cantrx_top #(.DOM_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_data_input(tx_data_input), .rx_data_output(rx_data_output), .bus_rx_state(bus_rx_state),
      .bus_tx_data(bus_tx_data), .bus_drv_en(bus_drv_en), .rx_only_mode(rx_only_mode), .sleep_state(sleep_state),
      .wake_enable_strap(wake_enable_strap), .overtemp_in(overtemp_in), .irq(irq));
   cantrx_ctrl_model ctrl_u (.pclk(pclk), .presetn(presetn), .go(go), .hold_dom(hold_dom), .frame(frame),
      .tx_data_input(tx_data_input));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task close_out;
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Hang guard, far above the planned run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         close_out;
      end
   end
   // One APB transfer; waits on pready, no fixed latency assumed
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(n, e, rd_q)
   endtask
   // Recessive gap, then n cycles of foreign dominant
   task dom(input int n);
      @(posedge pclk) ext_n <= 1'b1;
      repeat (10) @(posedge pclk);
      ext_n <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask
   initial begin
      {psel, penable, pwrite, rx_only_mode, sleep_state, overtemp_in, go, hold_dom, presetn} = '0;
      {wake_enable_strap, ext_n} = 2'b11;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      frame = 16'hA5C3;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // Same frame in normal then receive-only mode
      for (m = 0; m < 2; m++) begin
         @(posedge pclk) rx_only_mode <= m[0];
         repeat (3) @(posedge pclk);
         go <= 1'b1;
         @(posedge pclk) go <= 1'b0;
         q = 1'b1;
         repeat (18) begin
            #1 p = tx_data_input;
            @(posedge pclk);
            // In receive-only a foreign node plays the frame, so forwarding is seen
            ext_n <= p | ~m[0];
            #1 `CHK("bus tx", m[0] | p, bus_tx_data)
            `CHK("drv en", ~m[0], bus_drv_en)
            `CHK("rx out", q, rx_data_output)
            q = p;
         end
      end
      // Diagnosis stays live in receive-only mode
      @(posedge pclk) hold_dom <= 1'b1;
      repeat (30) @(posedge pclk);
      rd("diag", `CANTRX_DIAG_ADDR, 32'h0000_0002);
      rd("opstat", `CANTRX_OPERATING_STATUS_REGISTER_ZERO_ADDR, 32'h0000_000A);
      hold_dom <= 1'b0;
      overtemp_in <= 1'b1;
      repeat (3) @(posedge pclk);
      rd("diag", `CANTRX_DIAG_ADDR, 32'h0000_0004);
      overtemp_in <= 1'b0;
      rx_only_mode <= 1'b0;
      ext_n <= 1'b0;
      repeat (30) @(posedge pclk);
      rd("diag", `CANTRX_DIAG_ADDR, 32'h0000_0001);
      ext_n <= 1'b1;
      // Events latched while masked, irq only once unmasked
      #1 `CHK("irq", 1'b0, irq)
      rd("irq stat", `CANTRX_IRQ_STAT_ADDR, 32'h0000_000E);
      apb(1'b1, `CANTRX_IRQ_MASK_ADDR, 32'h0000_0002);
      repeat (2) @(posedge pclk);
      #1 `CHK("irq", 1'b1, irq)
      apb(1'b1, `CANTRX_IRQ_STAT_ADDR, 32'h0000_0002);
      repeat (2) @(posedge pclk);
      #1 `CHK("irq", 1'b0, irq)
      rd("irq stat", `CANTRX_IRQ_STAT_ADDR, 32'h0000_000C);
      rd("unmapped", 12'h020, 32'h0000_0000);
      `CHK("slverr", 1'b1, err_q)
      // Wake: short pulse, long pulse, clear under clamp, strap off
      sleep_state <= 1'b1;
      dom(100);
      rd("opstat", `CANTRX_OPERATING_STATUS_REGISTER_ZERO_ADDR, 32'h0000_000C);
      dom(250);
      rd("opstat", `CANTRX_OPERATING_STATUS_REGISTER_ZERO_ADDR, 32'h0000_000D);
      apb(1'b1, `CANTRX_COMMAND_REGISTER_ZERO_ADDR, 32'h0000_0001);
      repeat (300) @(posedge pclk);
      rd("opstat", `CANTRX_OPERATING_STATUS_REGISTER_ZERO_ADDR, 32'h0000_000C);
      wake_enable_strap <= 1'b0;
      dom(250);
      rd("opstat", `CANTRX_OPERATING_STATUS_REGISTER_ZERO_ADDR, 32'h0000_0004);
      // Clamp came back during the wake tests; clearing the mask drops irq
      #1 `CHK("irq", 1'b1, irq)
      apb(1'b1, `CANTRX_IRQ_MASK_ADDR, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      #1 `CHK("irq", 1'b0, irq)
      rd("irq stat", `CANTRX_IRQ_STAT_ADDR, 32'h0000_000F);
      close_out;
   end
endmodule // test_can_transceiver_mode_wake_diag
